// ==== core/sbcs_pkg.sv ====
// package for the static bus cycle sequencer: widths, defaults, phase states and carriers
package sbcs_pkg;

   // zone selection codes
   localparam logic [1:0] ZONE_MEM0   = 2'h0;
   localparam logic [1:0] ZONE_MEM1   = 2'h1;
   localparam logic [1:0] ZONE_IO     = 2'h2;
   localparam logic [1:0] ZONE_NONE   = 2'h3;

   // address decode: zone base addresses (upper address bits)
   localparam logic [1:0] DEC_IO_TOP  = 2'h0;
   localparam logic [1:0] DEC_MEM1    = 2'h1;
   localparam int         DEC_MSB     = 15;
   localparam int         DEC_LSB     = 14;

   // timing counts in clocks
   localparam logic [2:0] WAIT_NONE   = 3'h0;
   localparam logic [1:0] HOLD_NONE   = 2'h0;

   // reset value of the early write setting and the I/O address mask
   localparam logic       EARLY_WRITE_RST = 1'h1;
   localparam logic [7:0] IO_ADDR_MASK    = 8'hFF;

   // per-zone timing configuration
   typedef struct packed {
      logic       fastReadEnable;
      logic       postIdleEnable;
      logic       zoneBusWidth;     // 1: 16-bit, 0: 8-bit
      logic       burstWaitEnable;
      logic       burstReadEnable;
      logic [1:0] holdCount;
      logic [2:0] waitCount;
   } sbcs_zone_cfg_t;

   localparam sbcs_zone_cfg_t ZONE_CFG_RST = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 2'h3, 3'h7};

   // core bus request
   typedef struct packed {
      logic        write;
      logic [1:0]  byteEn;          // bit0 low byte, bit1 high byte
      logic [15:0] addr;
      logic [15:0] wdata;
      logic        ioExpansion;      // access targets an I/O expansion port
      logic        portOnChip;       // some pin of that port is on-chip
      logic        portAllInputs;    // all pins of that port are inputs
   } sbcs_req_t;

   // bus phase states
   typedef enum logic [3:0] {
      ST_IDLE      = 4'h0,
      ST_ADDR      = 4'h1,
      ST_WAIT      = 4'h2,
      ST_DATA      = 4'h3,
      ST_BWAIT     = 4'h4,
      ST_BDATA     = 4'h5,
      ST_RELEASE   = 4'h6,
      ST_HOLD      = 4'h7,
      ST_FAST      = 4'h8,
      ST_GAP       = 4'h9
   } sbcs_state_t;

endpackage

// ==== core/sbcs_sequencer.sv ====
// static bus cycle sequencer: core transactions to external memory and I/O expansion cycles
//
// How it works
// - byte zone word read: burst or two reads
// - writes never burst; byte zone word writes split into two
// - byte zone uses low strobe only
// - early write bit gives three-clock write
// - early write first clock: address, no data
// - early write data and select at wait/data
// - early write release: select and strobes drop together
// - holds keep address/data, then data floats
// - idle clock between early write and read
// - late write: select with address first clock
// - late write data from wait, strobes end data
// - late write select drops first hold
// - normal read select first, strobe at wait
// - sample data by zone bus width
// - read select and strobe drop at hold
// - burst adds optional wait then data state
// - fast read takes single clock
// - fast read select drops after its clock
// - fast read ignores wait/hold; idle after write
// - wide fast read splits into single clocks
// - I/O cycles use I/O select, A0-7, except the second cycle of a split word, which drives the full address
// - idle before I/O cycle, no I/O burst
// - zero to seven waits after address phase
// - zero to three holds keep address valid
// - post idle on zone change
`timescale 1ns/10ps

module sbcs_sequencer
   import sbcs_pkg::*;
(
   // clock and reset
   input  wire logic                    clk,
   input  wire logic                    rst,
   // zone configuration
   input  wire sbcs_pkg::sbcs_zone_cfg_t memoryZoneConfig0,
   input  wire sbcs_pkg::sbcs_zone_cfg_t memoryZoneConfig1,
   input  wire sbcs_pkg::sbcs_zone_cfg_t ioZoneConfig,
   input  wire logic                    earlyWriteSelect,
   // core bus
   input  wire logic                    reqValid,
   input  wire sbcs_pkg::sbcs_req_t     req,
   output logic                         reqReady,
   output logic                         rdataValid,
   output logic [15:0]                  rdata,
   output logic                         reqDropped,
   // external bus
   output logic [15:0]                  extAddr,
   input  wire logic [15:0]             extDataIn,
   output logic [15:0]                  extDataOut,
   output logic [15:0]                  extDataOe,
   output logic [1:0]                   zoneSelect_n,
   output logic                         ioZoneSelect_n,
   output logic                         readStrobe_n,
   output logic                         lowByteWriteStrobe_n,
   output logic                         highByteWriteStrobe_n
);
   import sbcs_pkg::*;

   // decode an address to a zone
   function automatic logic [1:0] zoneOf(input sbcs_req_t r);
      if (r.ioExpansion)
         zoneOf = ZONE_IO;
      else if (r.addr[DEC_MSB:DEC_LSB] == DEC_MEM1)
         zoneOf = ZONE_MEM1;
      else
         zoneOf = ZONE_MEM0;
   endfunction

   // pick a zone's configuration
   function automatic sbcs_zone_cfg_t cfgOf(input logic [1:0] z);
      unique case (z)
         ZONE_MEM0: cfgOf = memoryZoneConfig0;
         ZONE_MEM1: cfgOf = memoryZoneConfig1;
         default:   cfgOf = ioZoneConfig;
      endcase
   endfunction

   sbcs_state_t    state_r;
   sbcs_req_t      cur_r;
   sbcs_zone_cfg_t cfg_r;
   logic [1:0]     zone_r;
   logic [1:0]     lastZone_r;
   logic           lastWrite_r;
   logic           lastEarly_r;
   logic           lastFast_r;
   logic           early_r;
   logic           secondHalf_r;      // second byte of a split word
   logic           splitPending_r;
   logic [2:0]     cnt_r;
   logic           selActive_r;
   logic           rdActive_r;
   logic [1:0]     wrActive_r;
   logic           drive_r;
   logic [15:0]    addr_r;
   logic [7:0]     lowByte_r;

   sbcs_zone_cfg_t newCfg;
   sbcs_zone_cfg_t lastCfg;          // settings of the zone that ran last
   logic [1:0]     newZone;
   logic           newFast;
   logic           needGap;
   logic           dropReq;
   logic           splitWord;
   logic           startOk;
   logic           lastPhase;

   // request classification
   assign newZone   = zoneOf(req);
   assign newCfg    = cfgOf(newZone);
   assign newFast   = !req.write && newCfg.fastReadEnable && newZone != ZONE_IO;
   assign dropReq   = req.ioExpansion && (req.portOnChip || (req.write && req.portAllInputs));
   assign splitWord = !newCfg.zoneBusWidth && (req.byteEn == 2'h3);
   assign lastCfg   = cfgOf(lastZone_r);
   // one idle clock covers all reasons together; overlaps never stack
   assign needGap   = (lastEarly_r && !req.write)
                    || (lastWrite_r && newFast)
                    || (newZone == ZONE_IO)
                    || (lastCfg.postIdleEnable && lastZone_r != ZONE_NONE
                        && lastZone_r != newZone);
   assign lastPhase = (state_r == ST_IDLE) || (state_r == ST_GAP);
   assign startOk   = lastPhase && !splitPending_r;
   assign reqReady  = startOk && !(needGap && state_r != ST_GAP && !dropReq);
   assign reqDropped = reqValid && reqReady && dropReq;

   // phase sequencing
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         state_r        <= ST_IDLE;
         cur_r          <= '0;
         cfg_r          <= ZONE_CFG_RST;
         zone_r         <= ZONE_NONE;
         lastZone_r     <= ZONE_NONE;
         lastWrite_r    <= 1'b0;
         lastEarly_r    <= 1'b0;
         lastFast_r     <= 1'b0;
         early_r        <= EARLY_WRITE_RST;
         secondHalf_r   <= 1'b0;
         splitPending_r <= 1'b0;
         cnt_r          <= WAIT_NONE;
         addr_r         <= '0;
      end
      else
      begin
         unique case (state_r)
            ST_IDLE, ST_GAP:
            begin
               if (splitPending_r)
               begin
                  // second separate cycle of a split word
                  splitPending_r <= 1'b0;
                  secondHalf_r   <= 1'b1;
                  addr_r         <= cur_r.addr | 16'h0001;
                  state_r        <= lastFast_r ? ST_FAST : ST_ADDR;
               end
               else if (reqValid && reqReady && !dropReq)
               begin
                  cur_r        <= req;
                  cfg_r        <= newCfg;
                  zone_r       <= newZone;
                  early_r      <= earlyWriteSelect;
                  secondHalf_r <= 1'b0;
                  addr_r       <= (newZone == ZONE_IO) ? {8'h00, req.addr[7:0] & IO_ADDR_MASK} : req.addr;
                  state_r      <= newFast ? ST_FAST : ST_ADDR;
                  // writes never burst; reads burst only when enabled and not I/O
                  splitPending_r <= splitWord && (req.write || newFast || !newCfg.burstReadEnable
                                    || newZone == ZONE_IO);
               end
               else if (reqValid && reqReady && dropReq)
                  state_r <= ST_IDLE;
               else if (reqValid && needGap && state_r == ST_IDLE)
                  state_r <= ST_GAP;
               else
                  state_r <= ST_IDLE;
               if (state_r == ST_GAP || (reqValid && reqReady))
               begin
                  lastEarly_r <= 1'b0;
                  lastWrite_r <= 1'b0;
               end
            end
            ST_ADDR:
            begin
               cnt_r   <= cfg_r.waitCount;
               state_r <= (cfg_r.waitCount != WAIT_NONE) ? ST_WAIT : ST_DATA;
            end
            ST_WAIT:
            begin
               cnt_r <= cnt_r - 3'h1;
               if (cnt_r == 3'h1)
                  state_r <= ST_DATA;
            end
            ST_DATA:
            begin
               cnt_r <= {1'b0, cfg_r.holdCount};
               if (!cur_r.write && splitWordCur() && !splitPending_r && !secondHalf_r)
               begin
                  addr_r  <= cur_r.addr | 16'h0001;
                  state_r <= cfg_r.burstWaitEnable ? ST_BWAIT : ST_BDATA;
               end
               else if (cur_r.write && early_r)
                  state_r <= ST_RELEASE;
               else
                  state_r <= (cfg_r.holdCount != HOLD_NONE) ? ST_HOLD : ST_IDLE;
            end
            ST_BWAIT:
               state_r <= ST_BDATA;
            ST_BDATA:
               state_r <= (cfg_r.holdCount != HOLD_NONE) ? ST_HOLD : ST_IDLE;
            ST_RELEASE:
            begin
               cnt_r   <= {1'b0, cfg_r.holdCount};
               state_r <= (cfg_r.holdCount != HOLD_NONE) ? ST_HOLD : ST_IDLE;
            end
            ST_HOLD:
            begin
               cnt_r <= cnt_r - 3'h1;
               if (cnt_r == 3'h1)
                  state_r <= ST_IDLE;
            end
            ST_FAST:
               state_r <= ST_IDLE;
            default:
               state_r <= ST_IDLE;
         endcase
         // history for idle insertion, taken at the end of each cycle
         if (!lastPhase && nextIsIdle())
         begin
            lastZone_r  <= zone_r;
            lastWrite_r <= cur_r.write;
            lastEarly_r <= cur_r.write && early_r;
            lastFast_r  <= state_r == ST_FAST;
         end
      end
   end

   // word larger than zone width in flight
   function automatic logic splitWordCur();
      splitWordCur = !cfg_r.zoneBusWidth && cur_r.byteEn == 2'h3;
   endfunction

   // true on the final clock of a bus cycle
   function automatic logic nextIsIdle();
      unique case (state_r)
         ST_FAST, ST_BDATA: nextIsIdle = cfg_r.holdCount == HOLD_NONE || state_r == ST_FAST;
         ST_HOLD:           nextIsIdle = cnt_r == 3'h1;
         ST_RELEASE:        nextIsIdle = cfg_r.holdCount == HOLD_NONE;
         ST_DATA:           nextIsIdle = cfg_r.holdCount == HOLD_NONE && !(cur_r.write && early_r)
                                         && !(!cur_r.write && splitWordCur() && !splitPending_r && !secondHalf_r);
         default:           nextIsIdle = 1'b0;
      endcase
   endfunction

   // strobes, select and data drive; outputs change on the clock that enters each phase
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         selActive_r <= 1'b0;
         rdActive_r  <= 1'b0;
         wrActive_r  <= 2'h0;
         drive_r     <= 1'b0;
      end
      else
      begin
         unique case (state_r)
            ST_IDLE, ST_GAP:
            begin
               // select may stay on into a back-to-back same zone cycle
               selActive_r <= selActive_r && reqValid && reqReady && !dropReq && newZone == zone_r
                              && !(req.write && earlyWriteSelect);
               rdActive_r  <= 1'b0;
               wrActive_r  <= 2'h0;
               drive_r     <= 1'b0;
               if ((reqValid && reqReady && !dropReq) || splitPending_r)
               begin
                  if (splitPending_r ? lastFast_r : newFast)
                  begin
                     selActive_r <= 1'b1;
                     rdActive_r  <= 1'b1;
                  end
                  else if (splitPending_r ? (cur_r.write && early_r) : (req.write && earlyWriteSelect))
                     selActive_r <= 1'b0;
                  else
                     selActive_r <= 1'b1;
               end
            end
            ST_ADDR:
            begin
               if (cur_r.write)
               begin
                  wrActive_r  <= writeLanes();
                  drive_r     <= 1'b1;
                  selActive_r <= 1'b1;
               end
               else
                  rdActive_r  <= 1'b1;
            end
            ST_DATA, ST_BDATA:
            begin
               if (cur_r.write && early_r && state_r == ST_DATA)
               begin
                  selActive_r <= 1'b0;
                  wrActive_r  <= 2'h0;
               end
               else if (!nextIsIdle() && state_r == ST_DATA && !cur_r.write
                        && splitWordCur() && !secondHalf_r && !splitPending_r)
                  rdActive_r  <= 1'b1;
               else
               begin
                  wrActive_r  <= 2'h0;
                  rdActive_r  <= 1'b0;
                  if (cfg_r.holdCount != HOLD_NONE)
                     selActive_r <= 1'b0;
                  else
                     drive_r     <= 1'b0;
               end
            end
            ST_RELEASE, ST_HOLD:
            begin
               selActive_r <= 1'b0;
               wrActive_r  <= 2'h0;
               rdActive_r  <= 1'b0;
               // with no hold the release phase is the last one, so data floats after it
               if (state_r == ST_HOLD ? cnt_r == 3'h1 : cfg_r.holdCount == HOLD_NONE)
                  drive_r  <= 1'b0;
            end
            ST_FAST:
            begin
               rdActive_r  <= 1'b0;
               selActive_r <= 1'b0;
            end
            default:
            begin
               selActive_r <= selActive_r;
            end
         endcase
      end
   end

   // lanes to strobe: the request's lanes in a wide zone, the low lane only in a narrow one
   function automatic logic [1:0] writeLanes();
      if (!cfg_r.zoneBusWidth)
         writeLanes = 2'h1;
      else
         writeLanes = cur_r.byteEn;
   endfunction

   // data to put on the bus; a narrow zone always carries its byte on the low lane
   function automatic logic [15:0] writeData();
      if (!cfg_r.zoneBusWidth)
         writeData = {8'h00, (secondHalf_r || cur_r.byteEn == 2'h2) ? cur_r.wdata[15:8] : cur_r.wdata[7:0]};
      else
         writeData = cur_r.wdata;
   endfunction

   // read capture at the end of data and burst data phases
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         rdataValid <= 1'b0;
         rdata      <= '0;
         lowByte_r  <= '0;
      end
      else
      begin
         rdataValid <= 1'b0;
         if (!cur_r.write && (state_r == ST_DATA || state_r == ST_BDATA || state_r == ST_FAST))
         begin
            if (cfg_r.zoneBusWidth)
            begin
               rdata      <= extDataIn;
               rdataValid <= 1'b1;
            end
            else if (splitWordCur() && !secondHalf_r && state_r != ST_BDATA)
               lowByte_r  <= extDataIn[7:0];
            else if (splitWordCur())
            begin
               rdata      <= {extDataIn[7:0], lowByte_r};
               rdataValid <= 1'b1;
            end
            else
            begin
               rdata      <= (cur_r.byteEn == 2'h2) ? {extDataIn[7:0], 8'h00} : {8'h00, extDataIn[7:0]};
               rdataValid <= 1'b1;
            end
         end
      end
   end

   // pin drive from registered phase state
   assign extAddr               = addr_r;
   assign extDataOut            = drive_r ? writeData() : 16'h0000;
   assign extDataOe             = drive_r ? (cfg_r.zoneBusWidth ? {{8{cur_r.byteEn[1]}}, {8{cur_r.byteEn[0]}}}
                                                                : 16'h00FF) : 16'h0000;
   assign zoneSelect_n[0]       = !(selActive_r && zone_r == ZONE_MEM0);
   assign zoneSelect_n[1]       = !(selActive_r && zone_r == ZONE_MEM1);
   assign ioZoneSelect_n        = !(selActive_r && zone_r == ZONE_IO);
   assign readStrobe_n          = !rdActive_r;
   assign lowByteWriteStrobe_n  = !wrActive_r[0];
   assign highByteWriteStrobe_n = !wrActive_r[1];

endmodule

// ==== tb/sbcs_asserts.sv ====
// checker on the sequencer's external pins
`timescale 1ns/10ps
module sbcs_asserts
(
   // clock and reset
   input wire logic        clk,
   input wire logic        rst,
   // watched ports
   input wire logic        earlyWriteSelect,
   input wire logic        reqDropped,
   input wire logic        rdataValid,
   input wire logic [15:0] extDataOe,
   input wire logic [1:0]  zoneSelect_n,
   input wire logic        ioZoneSelect_n,
   input wire logic        readStrobe_n,
   input wire logic        lowByteWriteStrobe_n,
   input wire logic        highByteWriteStrobe_n
);
   logic selAct;
   logic wrAct;
   // folded select and strobe activity
   assign selAct = zoneSelect_n != 2'h3 || !ioZoneSelect_n;
   assign wrAct = !lowByteWriteStrobe_n || !highByteWriteStrobe_n;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   // strobe edges of a write
   sequence s_wr_start;
      !wrAct ##1 wrAct;
   endsequence
   sequence s_wr_end;
      wrAct ##1 !wrAct;
   endsequence
   a_strobe_excl: assert property (!(wrAct && !readStrobe_n))
      else $error("read and write strobes overlap");
   a_wr_data: assert property (wrAct |-> (lowByteWriteStrobe_n || &extDataOe[7:0]) && (highByteWriteStrobe_n || &extDataOe[15:8]))
      else $error("write strobe without its data byte");
   a_t1_float: assert property (s_wr_start |-> $past(extDataOe) == 16'h0)
      else $error("data driven in address phase");
   a_early_start: assert property (s_wr_start ##0 earlyWriteSelect |-> selAct && !$past(selAct))
      else $error("early write select timing");
   a_late_start: assert property (s_wr_start ##0 !earlyWriteSelect |-> selAct && $past(selAct))
      else $error("late write select not ahead of strobes");
   a_early_release: assert property (s_wr_end ##0 earlyWriteSelect |-> !selAct && extDataOe != 16'h0)
      else $error("early write release wrong");
   a_read_sel: assert property (!readStrobe_n |-> selAct && extDataOe == 16'h0)
      else $error("read strobe without select or with data driven");
   a_rdata_after: assert property (rdataValid |-> !$past(readStrobe_n))
      else $error("read result not after a sampled strobe");
   a_one_zone: assert property ($onehot0({~zoneSelect_n, ~ioZoneSelect_n}))
      else $error("two zones selected");
   a_io_idle: assert property ($fell(ioZoneSelect_n) |-> $past(zoneSelect_n) == 2'h3 && $past(readStrobe_n))
      else $error("no idle clock before io cycle");
   a_drop_quiet: assert property (reqDropped |=> ioZoneSelect_n)
      else $error("dropped io request selected the io zone");
endmodule

// ==== tb/sbcs_mem_model.sv ====
// behavioural static memory and io latch on the external pins
`timescale 1ns/10ps
module sbcs_mem_model
(
   // clock and answer speed
   input  wire logic        clk,
   input  wire logic        slow,
   // external bus
   input  wire logic [15:0] extAddr,
   input  wire logic [15:0] extDataOut,
   input  wire logic [1:0]  zoneSelect_n,
   input  wire logic        ioZoneSelect_n,
   input  wire logic        readStrobe_n,
   input  wire logic        lowByteWriteStrobe_n,
   input  wire logic        highByteWriteStrobe_n,
   output logic [15:0]      extDataIn
);
   logic [7:0]  mem [0:1023];
   logic [9:0]  ix;
   logic        selAct;
   logic        rdPrev = 1'b0;
   logic [15:0] lastData = 16'h0;
   // bank by zone, cell by low address byte; the io latch sees A0-7 only
   assign selAct = zoneSelect_n != 2'h3 || !ioZoneSelect_n;
   assign ix = {!ioZoneSelect_n ? 2'h2 : {1'b0, !zoneSelect_n[1]}, extAddr[7:0]};
   // writes land on every clock a strobe is active under a select
   always @(posedge clk)
   begin
      rdPrev <= selAct && !readStrobe_n;
      lastData <= extDataIn;
      if (selAct && !lowByteWriteStrobe_n)
         mem[ix] <= extDataOut[7:0];
      if (selAct && !highByteWriteStrobe_n)
         mem[ix | 10'h1] <= extDataOut[15:8];
   end
   // no pull-ups: off the bus the lines flip every clock, so stale data never passes
   always_comb
      if (selAct && !readStrobe_n && (!slow || rdPrev))
         extDataIn = {mem[ix | 10'h1], mem[ix]};
      else
         extDataIn = ~lastData;
endmodule

// ==== tb/static_bus_cycle_sequencer_test.sv ====
// self-checking bench for the static bus cycle sequencer
`timescale 1ns/10ps
module static_bus_cycle_sequencer_test;
   import sbcs_pkg::*;
   // timing sets: widths, waits 0, 1, 2 and 7, holds 0..3, burst with and without wait, fast read
   localparam logic [9:0] CFG_TAB [8] = '{10'h180, 10'h180, 10'h19F, 10'h120, 10'h16A, 10'h111, 10'h39F, 10'h31F};
   localparam logic [7:0] EW_TAB = 8'h96;
   localparam logic [7:0] SLOW_TAB = 8'h24;
   logic           clk, rst, earlyWriteSelect, reqValid, reqReady, rdataValid, reqDropped, slow;
   logic           ioZoneSelect_n, readStrobe_n, lowByteWriteStrobe_n, highByteWriteStrobe_n;
   logic [1:0]     zoneSelect_n;
   logic [15:0]    rdata, extAddr, extDataIn, extDataOut, extDataOe, a;
   sbcs_zone_cfg_t cfg, io_zone_config;
   sbcs_req_t      req;
   logic [7:0]     shadow [0:1023];
   logic [15:0]    notes [$];
   int             fail_count, compares, seed;

   sbcs_sequencer sbcs_sequencer_i (.clk(clk), .rst(rst), .memoryZoneConfig0(cfg), .memoryZoneConfig1(cfg),
      .ioZoneConfig(io_zone_config), .earlyWriteSelect(earlyWriteSelect), .reqValid(reqValid), .req(req),
      .reqReady(reqReady), .rdataValid(rdataValid), .rdata(rdata), .reqDropped(reqDropped), .extAddr(extAddr),
      .extDataIn(extDataIn), .extDataOut(extDataOut), .extDataOe(extDataOe), .zoneSelect_n(zoneSelect_n),
      .ioZoneSelect_n(ioZoneSelect_n), .readStrobe_n(readStrobe_n), .lowByteWriteStrobe_n(lowByteWriteStrobe_n),
      .highByteWriteStrobe_n(highByteWriteStrobe_n));
   sbcs_mem_model sbcs_mem_model_i (.clk(clk), .slow(slow), .extAddr(extAddr), .extDataOut(extDataOut),
      .zoneSelect_n(zoneSelect_n), .ioZoneSelect_n(ioZoneSelect_n), .readStrobe_n(readStrobe_n),
      .lowByteWriteStrobe_n(lowByteWriteStrobe_n), .highByteWriteStrobe_n(highByteWriteStrobe_n),
      .extDataIn(extDataIn));

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("wrong value at %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic tally_and_finish;
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // a wait that ran out counts as a mismatch and ends the run
   task automatic bail(input int n);
      if (n >= 500)
      begin
         fail_count++;
         tally_and_finish();
      end
   endtask

   // request held until accepted; reads not dropped leave their expected word in the queue
   task automatic issue(input logic wr, input logic [1:0] be, input logic [15:0] ad, input logic io,
                        input logic [1:0] port);
      int         n;
      logic [9:0] ix;
      ix = {io ? 2'h2 : {1'b0, ad[15:14] == 2'h1}, ad[7:0]};
      reqValid = 1'b1;
      req = '{wr, be, ad, 16'($random(seed)), io, port[1], port[0]};
      n = 0;
      @(negedge clk);
      while (reqReady !== 1'b1 && n < 500)
      begin
         @(negedge clk);
         n++;
      end
      bail(n);
      if (io && (port[1] || (wr && port[0])))
         check({15'h0, reqDropped}, 16'h1);
      else if (wr)
      begin
         if (be[0])
            shadow[ix] = req.wdata[7:0];
         if (be[1])
            shadow[ix | 10'h1] = req.wdata[15:8];
      end
      else
         notes.push_back({shadow[ix | 10'h1], shadow[ix]});
      @(posedge clk);
      #1;
   endtask

   // release the bus and wait for every pending read
   task automatic drain;
      int n;
      reqValid = 1'b0;
      n = 0;
      while (notes.size() != 0 && n < 500)
      begin
         @(negedge clk);
         n++;
      end
      bail(n);
      @(posedge clk);
      #1;
   endtask

   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // each read result is paired with the oldest note
   always @(posedge clk)
      if (rdataValid === 1'b1 && notes.size() == 0)
         check(16'h1, 16'h0);
      else if (rdataValid === 1'b1)
         check(rdata, notes.pop_front());

   initial
   begin
      seed = 32'hBB6BEB87;
      fail_count = 0;
      compares = 0;
      rst = 1'b1;
      reqValid = 1'b0;
      req = '0;
      cfg = ZONE_CFG_RST;
      io_zone_config = sbcs_zone_cfg_t'(10'h180);
      earlyWriteSelect = EARLY_WRITE_RST;
      slow = 1'b0;
      repeat (16) @(posedge clk);
      #1;
      rst = 1'b0;
      // zones alternate, so the post idle is crossed between sets
      for (int i = 0; i < 8; i++)
      begin
         cfg = sbcs_zone_cfg_t'(CFG_TAB[i]);
         earlyWriteSelect = EW_TAB[i];
         slow = SLOW_TAB[i];
         a = {1'b0, i[0], 6'h0, i[3:0], 4'h0};
         issue(1'b1, 2'h3, a + 16'h2, 1'b0, 2'h0);
         issue(1'b1, 2'h3, a, 1'b0, 2'h0);
         issue(1'b1, cfg.zoneBusWidth ? 2'h2 : 2'h1, a + 16'h2, 1'b0, 2'h0);
         issue(1'b0, 2'h3, a, 1'b0, 2'h0);
         issue(1'b0, 2'h3, a + 16'h2, 1'b0, 2'h0);
         drain();
      end
      // dropped write must leave the latch alone, so the last read sees the first word
      issue(1'b1, 2'h3, 16'h0010, 1'b1, 2'h0);
      issue(1'b1, 2'h3, 16'h0010, 1'b1, 2'h1);
      issue(1'b0, 2'h3, 16'h0010, 1'b1, 2'h2);
      issue(1'b0, 2'h3, 16'h0010, 1'b1, 2'h0);
      drain();
      tally_and_finish();
   end
endmodule

bind sbcs_sequencer sbcs_asserts sbcs_asserts_i (.clk(clk), .rst(rst), .earlyWriteSelect(earlyWriteSelect),
   .reqDropped(reqDropped), .rdataValid(rdataValid), .extDataOe(extDataOe), .zoneSelect_n(zoneSelect_n),
   .ioZoneSelect_n(ioZoneSelect_n), .readStrobe_n(readStrobe_n), .lowByteWriteStrobe_n(lowByteWriteStrobe_n),
   .highByteWriteStrobe_n(highByteWriteStrobe_n));
